// File: logic/iaf_pkg.sv
// Package for the interrogation acceptance filter
package iaf_pkg;
  localparam int CLK_MHZ = 100;
  // Pulse timing in nanoseconds
  localparam int MODE_A_NS = 8000;
  localparam int MODE_C_NS = 21000;
  localparam int P4_LONG_NS = 1600;
  localparam int TOL_NS = 200;
  localparam int RECOVER_NS = 15000;
  localparam int NS_PER_S = 1000000000;
  // Derived cycle counts
  localparam int MODE_A_CYC = MODE_A_NS * CLK_MHZ / 1000;
  localparam int MODE_C_CYC = MODE_C_NS * CLK_MHZ / 1000;
  localparam int P4_LONG_CYC = P4_LONG_NS * CLK_MHZ / 1000;
  localparam int TOL_CYC = TOL_NS * CLK_MHZ / 1000;
  localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int SEC_CYC = CLK_MHZ * 1000000;
  localparam int RATE_MIN = 100;
  localparam int RATE_MAX = 200;
  localparam logic [4:0] UF_ALLCALL = 5'h0B;
  localparam logic [23:0] ADDR_ALL_ONES = 24'hFFFFFF;
  localparam int IDENT_W = 48;

  typedef enum logic [2:0] {
    IAF_NONE = 3'h0,
    IAF_MODE_C = 3'h1,
    IAF_MODE_A = 3'h2,
    IAF_AC_ALLCALL = 3'h3,
    IAF_S_ALLCALL = 3'h4,
    IAF_OTHER = 3'h5
  } iaf_class_t;

  // Decoded ATCRBS pulse group from the demodulator
  typedef struct packed {
    logic valid;
    logic [15:0] p1p3_cyc;
    logic p4_seen;
    logic [15:0] p4_width_cyc;
  } iaf_atcrbs_t;

  // Decoded Mode S uplink header
  typedef struct packed {
    logic valid;
    logic [4:0] uf;
    logic [23:0] addr;
  } iaf_modes_t;
endpackage

// File: logic/iaf_window.sv
// Tolerance window compare on a measured cycle count
`timescale 1ns/1ps
module iaf_window #(
  parameter int CENTER = 0,
  parameter int TOL = 0
) (
  // Measurement
  input wire logic [15:0] value,
  // Result
  output logic hit
);
  localparam logic [16:0] LO = 17'(CENTER - TOL);
  localparam logic [16:0] HI = 17'(CENTER + TOL);
  always_comb begin
    hit = ({1'b0, value} >= LO) && ({1'b0, value} <= HI);
  end
endmodule // iaf_window

// File: logic/iaf_filter.sv
// Interrogation acceptance filter top
// Functional notes
// - Accept only Mode C among modes, all-calls
// - All-ones address with any UF rejected
// - Long P4 all-call rejected, no reply
// - Reject every UF 11, no lockout timers
// - No stochastic all-call acceptance at all
// - P1-P3 eight microsecond Mode A rejected
// - Mode A rejection triggers desensitize recovery
// - Ground load path for aircraft identification
// - Optional in-flight identification update
// - Mode C reply unless on ground
// - ATCRBS reply rate limit 100 to 200
`timescale 1ns/1ps
module iaf_filter
  import iaf_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Decoded interrogations
  input wire iaf_pkg::iaf_atcrbs_t atcrbs_in,
  input wire iaf_pkg::iaf_modes_t modes_in,
  // Aircraft state (pins)
  input wire logic on_ground_pin,
  input wire logic airborne_update_en_pin,
  // Crew identification entry (pin strobe)
  input wire logic ident_load_pin,
  input wire logic [iaf_pkg::IDENT_W-1:0] ident_data,
  // Rate limit setting, replies per second
  input wire logic [7:0] rate_limit,
  // Outputs
  output logic mode_c_reply,
  output logic reject_pulse,
  output iaf_pkg::iaf_class_t last_class,
  output logic rx_blank,
  output logic [iaf_pkg::IDENT_W-1:0] ident_value
);
  import iaf_pkg::*;

  logic gnd_s1, gnd;
  logic upd_s1, upd;
  logic ld_s1, ld_s2, ld_prev;
  logic hit_a, hit_c, hit_p4;
  logic [15:0] recover_cnt;
  logic [26:0] sec_cnt;
  logic [7:0] reply_cnt;
  logic [7:0] limit_eff;
  iaf_class_t next_class;
  logic [iaf_pkg::IDENT_W-1:0] id_s1, id_s2;
  logic accept_c;

  // Pin synchronisers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gnd_s1 <= 1'b1;
      gnd <= 1'b1;
      upd_s1 <= 1'b0;
      upd <= 1'b0;
      ld_s1 <= 1'b0;
      ld_s2 <= 1'b0;
      ld_prev <= 1'b0;
    end else begin
      gnd_s1 <= on_ground_pin;
      gnd <= gnd_s1;
      upd_s1 <= airborne_update_en_pin;
      upd <= upd_s1;
      ld_s1 <= ident_load_pin;
      ld_s2 <= ld_s1;
      ld_prev <= ld_s2;
    end
  end

  // Identification word through two stages, like its strobe
  // The word is held stable around the strobe, so no skew
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_s1 <= '0;
      id_s2 <= '0;
    end else begin
      id_s1 <= ident_data;
      id_s2 <= id_s1;
    end
  end

  iaf_window #(.CENTER(MODE_A_CYC), .TOL(TOL_CYC)) u_win_a (
    .value(atcrbs_in.p1p3_cyc),
    .hit(hit_a)
  );
  iaf_window #(.CENTER(MODE_C_CYC), .TOL(TOL_CYC)) u_win_c (
    .value(atcrbs_in.p1p3_cyc),
    .hit(hit_c)
  );
  iaf_window #(.CENTER(P4_LONG_CYC), .TOL(TOL_CYC)) u_win_p4 (
    .value(atcrbs_in.p4_width_cyc),
    .hit(hit_p4)
  );

  // Classification; Mode S wins if both arrive together
  always_comb begin
    next_class = IAF_NONE;
    if (modes_in.valid) begin
      // any UF 11 is an all-call, no lockout check
      if (modes_in.uf == UF_ALLCALL)
        next_class = IAF_S_ALLCALL;
      else if (modes_in.addr == ADDR_ALL_ONES)
        next_class = IAF_S_ALLCALL;
      else
        next_class = IAF_OTHER;
    end else if (atcrbs_in.valid) begin
      // long P4 marks the combined all-call
      if (atcrbs_in.p4_seen && hit_p4)
        next_class = IAF_AC_ALLCALL;
      else if (hit_a)
        next_class = IAF_MODE_A;
      else if (hit_c)
        next_class = IAF_MODE_C;
      else
        next_class = IAF_OTHER;
    end
  end

  always_comb begin
    if (rate_limit < 8'(RATE_MIN))
      limit_eff = 8'(RATE_MIN);
    else if (rate_limit > 8'(RATE_MAX))
      limit_eff = 8'(RATE_MAX);
    else
      limit_eff = rate_limit;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sec_cnt <= 27'h0000000;
    end else if (sec_cnt == 27'(SEC_CYC - 1)) begin
      sec_cnt <= 27'h0000000;
    end else begin
      sec_cnt <= sec_cnt + 27'h0000001;
    end
  end

  // Mode C acceptance this cycle
  always_comb begin
    accept_c = (next_class == IAF_MODE_C) && !gnd &&
      (recover_cnt == 16'h0000) && (reply_cnt < limit_eff);
  end

  // replies counted per window
  // A reply in the wrap cycle is not counted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reply_cnt <= 8'h00;
    end else if (sec_cnt == 27'(SEC_CYC - 1)) begin
      reply_cnt <= 8'h00;
    end else if (accept_c) begin
      reply_cnt <= reply_cnt + 8'h01;
    end
  end

  // Reply decision
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_c_reply <= 1'b0;
      reject_pulse <= 1'b0;
    end else begin
      // only Mode C may reach the reply generator
      mode_c_reply <= accept_c;
      // every all-call and Mode A rejected
      // Refused Mode C stays silent, no reject pulse
      reject_pulse <= (next_class == IAF_MODE_A) ||
        (next_class == IAF_AC_ALLCALL) || (next_class == IAF_S_ALLCALL);
    end
  end

  // Class of the last interrogation seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      last_class <= IAF_NONE;
    else if (next_class != IAF_NONE)
      last_class <= next_class;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      recover_cnt <= 16'h0000;
      rx_blank <= 1'b0;
    end else begin
      if (next_class == IAF_MODE_A) begin
        recover_cnt <= 16'(RECOVER_CYC);
        rx_blank <= 1'b1;
      end else if (recover_cnt != 16'h0000) begin
        recover_cnt <= recover_cnt - 16'h0001;
        rx_blank <= (recover_cnt != 16'h0001);
      end else begin
        rx_blank <= 1'b0;
      end
    end
  end

  // Identification entry on rising edge of load strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ident_value <= '0;
    end else if (ld_s2 && !ld_prev) begin
      if (gnd || upd)
        ident_value <= id_s2;
    end
  end
endmodule // iaf_filter

// File: tb/iaf_properties.sv
// Port checker for the acceptance filter
`timescale 1ns/1ps
module iaf_props
  import iaf_pkg::*;
(
  // Watched ports
  input wire logic sys_clk,
  input wire logic rst,
  input wire iaf_pkg::iaf_atcrbs_t atcrbs_in,
  input wire iaf_pkg::iaf_modes_t modes_in,
  input wire logic on_ground_pin,
  input wire logic mode_c_reply,
  input wire logic reject_pulse,
  input wire iaf_pkg::iaf_class_t last_class,
  input wire logic rx_blank
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire av = atcrbs_in.valid && !modes_in.valid;
  wire s11 = modes_in.valid && modes_in.uf == UF_ALLCALL;
  wire sx = modes_in.valid && !s11 && modes_in.addr != ADDR_ALL_ONES;
  wire p4 = av && atcrbs_in.p4_seen;
  wire ma = av && !p4 && atcrbs_in.p1p3_cyc == 16'(MODE_A_CYC);
  property p_s11; s11 |=> reject_pulse && last_class == IAF_S_ALLCALL;
  endproperty
  a_s11: assert property (p_s11) else $error("uf11");
  property p_sx; sx |=> !reject_pulse && !mode_c_reply; endproperty
  a_sx: assert property (p_sx) else $error("other");
  property p_p4; p4 && atcrbs_in.p4_width_cyc == 16'(P4_LONG_CYC)
    |=> reject_pulse && last_class == IAF_AC_ALLCALL; endproperty
  a_p4: assert property (p_p4) else $error("p4");
  property p_ma; ma |=> reject_pulse && rx_blank; endproperty
  a_ma: assert property (p_ma) else $error("mode a");
  property p_bl; rx_blank && av |=> !mode_c_reply; endproperty
  a_bl: assert property (p_bl) else $error("blank");
  property p_ex; !(mode_c_reply && reject_pulse); endproperty
  a_ex: assert property (p_ex) else $error("both");
  property p_cr; mode_c_reply |-> last_class == IAF_MODE_C && $past(av);
  endproperty
  a_cr: assert property (p_cr) else $error("reply");
  property p_gd; on_ground_pin [*5] |=> !mode_c_reply; endproperty
  a_gd: assert property (p_gd) else $error("ground");
  c_rep: cover property (mode_c_reply);
  c_rej: cover property (reject_pulse);
  c_bl: cover property ($fell(rx_blank));
endmodule // iaf_props
bind iaf_filter iaf_props u_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .atcrbs_in(atcrbs_in),
  .modes_in(modes_in),
  .on_ground_pin(on_ground_pin),
  .mode_c_reply(mode_c_reply),
  .reject_pulse(reject_pulse),
  .last_class(last_class),
  .rx_blank(rx_blank)
);

// File: tb/iaf_interrogator.sv
// Interrogator model driving decoded interrogations
`timescale 1ns/1ps
module iaf_interrogator
  import iaf_pkg::*;
(
  // Decoded interrogations
  input wire logic sys_clk,
  output iaf_pkg::iaf_atcrbs_t atcrbs_in,
  output iaf_pkg::iaf_modes_t modes_in
);
  initial begin
    atcrbs_in = '0;
    modes_in = '0;
  end
  // Fields are scrambled once valid drops
  task automatic atc(input logic [15:0] sp, input logic p,
                     input logic [15:0] w);
    @(negedge sys_clk);
    atcrbs_in <= {1'b1, sp, p, w};
    @(negedge sys_clk);
    atcrbs_in <= {1'b0, ~sp, ~p, 16'hA5A5};
  endtask
  task automatic mds(input logic [4:0] u, input logic [23:0] a);
    @(negedge sys_clk);
    modes_in <= {1'b1, u, a};
    @(negedge sys_clk);
    modes_in <= {1'b0, ~u, ~a};
  endtask
endmodule // iaf_interrogator

// File: tb/tb_top.sv
// Testbench for the acceptance filter
`timescale 1ns/1ps
module tb_top;
  import iaf_pkg::*;
  logic sys_clk = 0, rst = 1, gnd = 1, upd = 0, ld = 0, cr, rj, bl;
  logic [47:0] idd = '0, idv;
  logic [7:0] rate = 8'hC8;
  iaf_atcrbs_t at;
  iaf_modes_t ms;
  iaf_class_t cls;
  int n_fail = 0, total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  iaf_interrogator src (.sys_clk(sys_clk), .atcrbs_in(at), .modes_in(ms));
  iaf_filter dut (.sys_clk(sys_clk), .rst(rst), .atcrbs_in(at),
    .modes_in(ms), .on_ground_pin(gnd), .airborne_update_en_pin(upd),
    .ident_load_pin(ld), .ident_data(idd), .rate_limit(rate),
    .mode_c_reply(cr), .reject_pulse(rj), .last_class(cls),
    .rx_blank(bl), .ident_value(idv));
  task automatic chk(input string n, input logic [47:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic res(input logic c, r, input iaf_class_t k);
    chk("reply", c, cr);
    chk("reject", r, rj);
    chk("class", k, cls);
  endtask
  task automatic s_id(input logic g, u, input logic [47:0] d, e);
    gnd = g;
    upd = u;
    idd = d;
    repeat (4) @(negedge sys_clk);
    ld = 1;
    repeat (6) @(negedge sys_clk);
    ld = 0;
    chk("ident", e, idv);
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Mode C on the ground stays silent, then leave the ground
  task automatic t_ground;
    src.atc(MODE_C_CYC, 0, 0);
    res(0, 0, IAF_MODE_C);
    gnd = 0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Mode C spacing window, both inside and just outside
  task automatic t_mode_c;
    src.atc(MODE_C_CYC, 0, 0);
    res(1, 0, IAF_MODE_C);
    src.atc(MODE_C_CYC + TOL_CYC, 0, 0);
    res(1, 0, IAF_MODE_C);
    src.atc(MODE_C_CYC + TOL_CYC + 1, 0, 0);
    res(0, 0, IAF_OTHER);
  endtask
  // All-call variants are rejected, plain Mode S ignored
  task automatic t_allcall;
    src.mds(UF_ALLCALL, ADDR_ALL_ONES);
    res(0, 1, IAF_S_ALLCALL);
    src.mds(UF_ALLCALL, 24'h00A5C3);
    res(0, 1, IAF_S_ALLCALL);
    src.atc(MODE_C_CYC, 1, P4_LONG_CYC);
    res(0, 1, IAF_AC_ALLCALL);
    src.mds(5'h04, 24'h123456);
    res(0, 0, IAF_OTHER);
  endtask
  // Mode A rejected, receiver blanked for the recovery time
  task automatic t_mode_a;
    src.atc(MODE_A_CYC, 0, 0);
    res(0, 1, IAF_MODE_A);
    chk("blank", 1, bl);
    src.atc(MODE_C_CYC, 0, 0);
    res(0, 0, IAF_MODE_C);
    repeat (RECOVER_CYC - 3) @(negedge sys_clk);
    chk("blank", 1, bl);
    repeat (3) @(negedge sys_clk);
    chk("blank", 0, bl);
    src.atc(MODE_C_CYC, 0, 0);
    res(1, 0, IAF_MODE_C);
  endtask
  // Identification load on ground and with in-flight enable
  task automatic t_ident;
    s_id(1, 0, 48'hA1B2C3D4, 48'hA1B2C3D4);
    s_id(0, 0, 48'h5, 48'hA1B2C3D4);
    s_id(0, 1, 48'h5, 48'h5);
  endtask
  // Mid-run reset clears state and the rate window
  task automatic t_reset;
    rst = 1;
    repeat (2) @(negedge sys_clk);
    chk("ident", 0, idv);
    chk("class", IAF_NONE, cls);
    chk("blank", 0, bl);
    chk("reply", 0, cr);
    rst = 0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Burst of Mode C in one window, replies capped at the limit
  task automatic t_rate(input logic [7:0] r, input int e);
    int n = 0;
    rate = r;
    repeat (e + 10) begin
      src.atc(MODE_C_CYC, 0, 0);
      if (cr === 1'b1) n++;
    end
    chk("rate", 48'(e), 48'(n));
    chk("reject", 0, rj);
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 0;
    repeat (4) @(negedge sys_clk);
    t_ground();
    t_mode_c();
    t_allcall();
    t_mode_a();
    t_ident();
    t_reset();
    // Below the range, the limit clamps to the minimum
    t_rate(8'h32, RATE_MIN);
    t_reset();
    t_rate(8'h96, 150);
    conclude();
  end
  // Watchdog: the run needs about 2130 cycles
  initial begin
    #100us;
    n_fail++;
    conclude();
  end
endmodule // tb_top
